// ==== verilog/sld_pkg.sv ====
// constants and types shared by the segment panel driver
package sld_pkg;
   localparam int          SLD_SEGS        = 16;
   localparam int          SLD_COMS        = 4;
   localparam int          SLD_DATA_W      = 8;
   localparam int          SLD_IDX_LSB     = 0;
   localparam int          SLD_IDX_W       = 4;
   localparam int          SLD_PIX_W       = 4;
   localparam int          SLD_PRE_MIN_LOG = 4;
   localparam int          SLD_PRE_W       = 7;
   localparam int          SLD_FRAME_TICKS = 8;
   localparam int          SLD_SYNC_W      = 3;
   localparam logic [3:0]  SLD_PIX_RESET   = 4'h0;
   localparam logic [3:0]  SLD_CONTRAST_RST = 4'h0;
   localparam logic [2:0]  SLD_BIAS_OFF    = 3'h0;
   localparam logic        SLD_SRC_RC      = 1'b0;
   localparam logic        SLD_SRC_XTAL    = 1'b1;
   // bias level codes on each pin: gnd, v1 (1/3), v2 (2/3), vlcd
   localparam logic [1:0]  SLD_LVL_GND     = 2'h0;
   localparam logic [1:0]  SLD_LVL_V1      = 2'h1;
   localparam logic [1:0]  SLD_LVL_V2      = 2'h2;
   localparam logic [1:0]  SLD_LVL_VLCD    = 2'h3;
   typedef enum logic [1:0] {SLD_RATE_16, SLD_RATE_32, SLD_RATE_64, SLD_RATE_128} sld_rate_e;
endpackage

// ==== verilog/sld_tick_gen.sv ====
// edge detect of the low-speed clock and prescaler to the frame tick
`timescale 1ns/1ns
module sld_tick_gen (
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             nrst_i,
   // low-speed sources, asynchronous to sys_clk_i
   input  wire logic             rc_clk_i,
   input  wire logic             xtal_clk_i,
   // control
   input  wire logic             src_sel_i,
   input  wire sld_pkg::sld_rate_e rate_i,
   input  wire logic             run_i,
   // one cycle pulse per frame tick period
   output logic                  tick_o
);
   import sld_pkg::*;
   typedef struct packed {
      logic [SLD_SYNC_W-1:0] rc_sy;
      logic [SLD_SYNC_W-1:0] xt_sy;
      logic                  lvl;
      logic [SLD_PRE_W-1:0]  pre;
      logic                  tick;
   } sld_tick_s;
   sld_tick_s st_q, st_d;
   logic        rise;
   logic [SLD_PRE_W-1:0] lim;
   always_comb begin
      st_d       = st_q;
      st_d.rc_sy = {st_q.rc_sy[SLD_SYNC_W-2:0], rc_clk_i};
      st_d.xt_sy = {st_q.xt_sy[SLD_SYNC_W-2:0], xtal_clk_i};
      // a level counts once stages two and three agree
      if (st_q.rc_sy[2] == st_q.rc_sy[1] && src_sel_i == SLD_SRC_RC) begin // RULE3 RULE17
         st_d.lvl = st_q.rc_sy[1];
      end else if (st_q.xt_sy[2] == st_q.xt_sy[1] && src_sel_i == SLD_SRC_XTAL) begin // RULE17
         st_d.lvl = st_q.xt_sy[1];
      end
      rise      = st_d.lvl & ~st_q.lvl;
      lim       = SLD_PRE_W'((1 << (SLD_PRE_MIN_LOG + int'(rate_i))) - 1); // RULE4
      st_d.tick = 1'b0;
      if (!run_i) begin
         st_d.pre = '0;
      end else if (rise) begin
         if (st_q.pre >= lim) begin
            st_d.pre  = '0;
            st_d.tick = 1'b1;
         end else begin
            st_d.pre = st_q.pre + 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign tick_o = st_q.tick;
endmodule // sld_tick_gen

// ==== verilog/sld_panel_drv.sv ====
// segment panel driver: map memory, frame timing, pin handover
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: static select 0 gives 1/3 bias 1/4 duty, 1 gives static mode.
// RULE2: up to 16 segment pins against up to 4 common pins.
// RULE3: base clock is internal 16KHz RC or external 32.768KHz crystal.
// RULE4: prescaler divides base clock by 16, 32, 64 or 128 per rate code.
// RULE5: every frame lasts exactly eight frame ticks.
// RULE6: enabled: all commons drive; each segment drives only if selected.
// RULE7: disabled: all common and segment pins go back to GPIO.
// RULE8: static mode: bias switches off, pins driven by GPIO latches low or high.
// RULE9: static mode switches off contrast and bias control circuits.
// RULE10: 4-bit contrast code picks one of 16 supply levels.
// RULE11: map is 16 by 4 bits, reached only via index and data port.
// RULE12: low index nibble selects segment 0 to 15; upper nibble ignored.
// RULE13: software sets index before writing the data port.
// RULE14: data bits 0-3 hold commons 0-3; upper data bits ignored.
// RULE15: software finishes pin, mode, clock, contrast and map setup first.
// RULE16: runs in idle; in stop only on low-speed clock with keep bit set.
// RULE17: clock source 0 is internal RC, 1 is external crystal.
// RULE18: software enables the crystal before selecting it.
// RULE19: segment select 0 keeps GPIO, 1 makes a segment output.
// RULE20: multiplexed mode scans four commons and alternates polarity for zero DC.
module sld_panel_drv (
   // clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       nrst_i,
   // low-speed clocks
   input  wire logic                       rc_clk_i,
   input  wire logic                       xtal_clk_i,
   // control bits
   input  wire logic                       panel_drive_enable_i,
   input  wire logic                       static_select_i,
   input  wire logic                       frame_clock_source_sel_i,
   input  wire sld_pkg::sld_rate_e         frame_prescale_sel_i,
   input  wire logic [3:0]                 contrast_level_i,
   input  wire logic [2:0]                 bias_resistor_sel_i,
   input  wire logic [7:0]                 segment_pin_select_low_i,
   input  wire logic [7:0]                 segment_pin_select_high_i,
   // power state
   input  wire logic                       stop_mode_i,
   input  wire logic                       stop_wake_keep_i,
   // map access
   input  wire logic                       map_index_wr_i,
   input  wire logic                       map_data_wr_i,
   input  wire logic [sld_pkg::SLD_DATA_W-1:0] map_wdata_i,
   output logic [sld_pkg::SLD_DATA_W-1:0]  map_index_o,
   output logic [sld_pkg::SLD_DATA_W-1:0]  map_data_port_o,
   // pin ownership and drive
   output logic [sld_pkg::SLD_COMS-1:0]    com_own_o,
   output logic [sld_pkg::SLD_SEGS-1:0]    seg_own_o,
   output logic [2*sld_pkg::SLD_COMS-1:0]  com_level_o,
   output logic [2*sld_pkg::SLD_SEGS-1:0]  seg_level_o,
   output logic [sld_pkg::SLD_COMS-1:0]    com_latch_o,
   output logic [sld_pkg::SLD_SEGS-1:0]    seg_latch_o,
   output logic                            bias_switch_en_o,
   // analog controls
   output logic                            contrast_en_o,
   output logic [3:0]                      contrast_code_o,
   output logic                            bias_ctrl_en_o,
   output logic [2:0]                      bias_res_sel_o,
   // status
   output logic [1:0]                      active_com_o,
   output logic                            frame_start_o
);
   import sld_pkg::*;

   typedef struct packed {
      logic [SLD_IDX_W-1:0]      idx;
      logic [2:0]                step;
      logic                      frm;
      logic                      pol;
      logic [SLD_COMS-1:0]       com_own;
      logic [SLD_SEGS-1:0]       seg_own;
      logic [2*SLD_COMS-1:0]     com_lvl;
      logic [2*SLD_SEGS-1:0]     seg_lvl;
      logic [SLD_COMS-1:0]       com_lat;
      logic [SLD_SEGS-1:0]       seg_lat;
      logic                      bsw;
      logic                      con_en;
      logic [3:0]                con;
      logic                      bia_en;
      logic [2:0]                bia;
      logic [SLD_PIX_W-1:0]      rdat;
   } sld_drv_s;

   sld_drv_s st_q, st_d;
   logic [SLD_PIX_W-1:0] map_q [SLD_SEGS]; // RULE11
   logic                 tick;
   logic                 run;
   logic [SLD_SEGS-1:0]  seg_sel;
   logic [1:0]           cs;
   logic                 on;

   // multiplexed level: selected = full swing, else 1/3 swing, inverted by polarity
   function automatic logic [1:0] sld_level(input logic com, input logic pix,
                                            input logic pol);
      logic [1:0] l;
      l = SLD_LVL_GND;
      if (com) begin
         l = pix ? SLD_LVL_VLCD : SLD_LVL_V1;
      end else begin
         l = pix ? SLD_LVL_GND : SLD_LVL_V2;
      end
      if (pol) begin
         l = SLD_LVL_VLCD - l; // RULE20
      end
      return l;
   endfunction

   // stop mode keeps running only off the crystal with keep set
   assign run = panel_drive_enable_i &
                (~stop_mode_i | (stop_wake_keep_i &
                 frame_clock_source_sel_i == SLD_SRC_XTAL)); // RULE16
   assign seg_sel = {segment_pin_select_high_i, segment_pin_select_low_i}; // RULE2
   assign on      = panel_drive_enable_i;

   sld_tick_gen u_tick (
      .sys_clk_i  (sys_clk_i),
      .nrst_i     (nrst_i),
      .rc_clk_i   (rc_clk_i),
      .xtal_clk_i (xtal_clk_i),
      .src_sel_i  (frame_clock_source_sel_i),
      .rate_i     (frame_prescale_sel_i),
      .run_i      (run),
      .tick_o     (tick)
   );

   always_comb begin
      st_d     = st_q;
      st_d.frm = 1'b0;
      cs       = st_q.step[2:1];
      if (map_index_wr_i) begin
         st_d.idx = map_wdata_i[SLD_IDX_LSB +: SLD_IDX_W]; // RULE12
      end
      st_d.rdat = map_q[st_q.idx];
      // eight ticks per frame; two per common, polarity flips within the pair
      if (!on) begin
         st_d.step = '0;
         st_d.pol  = 1'b0;
      end else if (tick) begin
         st_d.step = st_q.step + 1'b1; // RULE5
         st_d.pol  = ~st_q.pol; // RULE20
         st_d.frm  = (st_q.step == 3'(SLD_FRAME_TICKS - 1));
      end
      st_d.com_own = on ? '1 : '0; // RULE6 RULE7
      st_d.seg_own = on ? seg_sel : '0; // RULE19 RULE7
      st_d.bsw     = on & ~static_select_i; // RULE8 RULE1
      st_d.con_en  = on & ~static_select_i; // RULE9
      st_d.bia_en  = on & ~static_select_i & (bias_resistor_sel_i != SLD_BIAS_OFF); // RULE9
      st_d.con     = contrast_level_i; // RULE10
      st_d.bia     = bias_resistor_sel_i;
      for (int c = 0; c < SLD_COMS; c++) begin
         // selected common swings full, the rest sit one third off the rail
         st_d.com_lvl[2*c +: 2] = sld_level(1'b1, cs == 2'(c), st_q.pol); // RULE1 RULE20
         // static: every common carries the backplane square wave
         st_d.com_lat[c] = on & static_select_i & st_q.pol; // RULE8
      end
      for (int s = 0; s < SLD_SEGS; s++) begin
         // lit pixel opposes the selected common, so it sees the full swing
         st_d.seg_lvl[2*s +: 2] = sld_level(1'b0, map_q[s][cs], st_q.pol); // RULE1
         st_d.seg_lat[s] = on & static_select_i & seg_sel[s] &
                           (st_q.pol ^ map_q[s][0]); // RULE8
      end
      if (!on || static_select_i) begin
         st_d.com_lvl = '0;
         st_d.seg_lvl = '0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // map has no reset; software loads it before enabling
   always_ff @(posedge sys_clk_i) begin
      if (map_data_wr_i) begin
         map_q[st_q.idx] <= map_wdata_i[SLD_PIX_W-1:0]; // RULE14
      end
   end

   assign map_index_o      = {4'h0, st_q.idx};
   assign map_data_port_o  = {4'h0, st_q.rdat};
   assign com_own_o        = st_q.com_own;
   assign seg_own_o        = st_q.seg_own;
   assign com_level_o      = st_q.com_lvl;
   assign seg_level_o      = st_q.seg_lvl;
   assign com_latch_o      = st_q.com_lat;
   assign seg_latch_o      = st_q.seg_lat;
   assign bias_switch_en_o = st_q.bsw;
   assign contrast_en_o    = st_q.con_en;
   assign contrast_code_o  = st_q.con;
   assign bias_ctrl_en_o   = st_q.bia_en;
   assign bias_res_sel_o   = st_q.bia;
   assign active_com_o     = st_q.step[2:1];
   assign frame_start_o    = st_q.frm;

   static_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      static_select_i |=> !bias_switch_en_o && !contrast_en_o) // RULE9
      else $error("static mode left bias active");
   gpio_back_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      !panel_drive_enable_i |=> com_own_o == '0 && seg_own_o == '0) // RULE7
      else $error("pins not returned to gpio");
   coms_own_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      panel_drive_enable_i |=> com_own_o == '1) // RULE6
      else $error("commons not owned");
   seg_pick_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      panel_drive_enable_i |=> seg_own_o == $past(seg_sel)) // RULE19
      else $error("segment ownership wrong");
   idx_load_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      map_index_wr_i |=> map_index_o == {4'h0, $past(map_wdata_i[3:0])}) // RULE12
      else $error("index not loaded");
   frame_len_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      frame_start_o |-> active_com_o == 2'h0 && st_q.step == 3'h0) // RULE5
      else $error("frame length not eight ticks");
   contrast_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      ##1 contrast_code_o == $past(contrast_level_i)) // RULE10
      else $error("contrast code not passed");
   mux_sw_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      panel_drive_enable_i && !static_select_i |=> bias_switch_en_o) // RULE1
      else $error("bias switch off in multiplexed mode");
endmodule // sld_panel_drv

// ==== verification/sld_panel_model.sv ====
// panel glass model: frame length and commons scanned per frame
`timescale 1ns/1ns
module sld_panel_model (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // from the panel driver
   input  wire logic        frame_start_i,
   input  wire logic [1:0]  active_com_i,
   // observations
   output logic [15:0]      period_o,
   output logic [3:0]       coms_seen_o
);
   logic [15:0] cnt_q;
   logic [3:0]  seen_q;
   // glass only cares how long a frame is and which commons it scanned
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q       <= 16'h0000;
         seen_q      <= 4'h0;
         period_o    <= 16'h0000;
         coms_seen_o <= 4'h0;
      end else if (frame_start_i) begin
         period_o    <= cnt_q + 16'h0001;
         coms_seen_o <= seen_q | (4'h1 << active_com_i);
         cnt_q       <= 16'h0000;
         seen_q      <= 4'h0;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
         seen_q <= seen_q | (4'h1 << active_com_i);
      end
   end
endmodule // sld_panel_model

// ==== verification/test_sld_panel_drv.sv ====
// self-checking bench of the segment panel driver
`timescale 1ns/1ns
module test_sld_panel_drv;
   import sld_pkg::*;
   logic clk, nrst, rc_clk, xt_clk, en, stc, src, wi, wd, stop, keep;
   sld_rate_e rate;
   logic [3:0]  vl;
   logic [2:0]  bsel;
   logic [7:0]  sl, sh, wdat, idx_o, dat_o;
   logic [3:0]  cown, clat, seen;
   logic [15:0] sown, slat, per;
   logic [7:0]  clvl;
   logic [31:0] slvl;
   logic        bsw, cen, ben, fs;
   logic [3:0]  ccode;
   logic [2:0]  bres;
   logic [1:0]  acom;
   int          error_cnt, checks_done, n;
   initial begin clk = 0; forever #25 clk = ~clk; end
   // low-speed clocks far faster than real so frames stay short
   initial begin xt_clk = 0; forever #250 xt_clk = ~xt_clk; end
   initial begin rc_clk = 0; forever #300 rc_clk = ~rc_clk; end
   sld_panel_drv u_sld_panel_drv (.sys_clk_i(clk), .nrst_i(nrst), .rc_clk_i(rc_clk),
      .xtal_clk_i(xt_clk), .panel_drive_enable_i(en), .static_select_i(stc),
      .frame_clock_source_sel_i(src), .frame_prescale_sel_i(rate), .contrast_level_i(vl),
      .bias_resistor_sel_i(bsel), .segment_pin_select_low_i(sl),
      .segment_pin_select_high_i(sh), .stop_mode_i(stop), .stop_wake_keep_i(keep),
      .map_index_wr_i(wi), .map_data_wr_i(wd), .map_wdata_i(wdat), .map_index_o(idx_o),
      .map_data_port_o(dat_o), .com_own_o(cown), .seg_own_o(sown), .com_level_o(clvl),
      .seg_level_o(slvl), .com_latch_o(clat), .seg_latch_o(slat), .bias_switch_en_o(bsw),
      .contrast_en_o(cen), .contrast_code_o(ccode), .bias_ctrl_en_o(ben),
      .bias_res_sel_o(bres), .active_com_o(acom), .frame_start_o(fs));
   sld_panel_model u_sld_panel_model (.sys_clk_i(clk), .nrst_i(nrst), .frame_start_i(fs),
      .active_com_i(acom), .period_o(per), .coms_seen_o(seen));
   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks_done++;
      if (seen_v !== exp_v) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   // index first, then data; sample two edges after the data strobe
   task automatic map_wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge clk); wi <= 1'b1; wdat <= i;
      @(posedge clk); wi <= 1'b0; wd <= 1'b1; wdat <= d;
      @(posedge clk); wd <= 1'b0;
      cyc(2);
      @(negedge clk);
   endtask
   // bounded wait for the next frame wrap
   task automatic wait_frame();
      int k;
      for (k = 0; k < 25000; k++) begin
         @(negedge clk);
         if (fs === 1'b1) break;
      end
      if (k == 25000) begin
         check(32'h0, 32'h1);
         give_verdict();
      end
   endtask
   initial begin
      error_cnt = 0; checks_done = 0;
      nrst = 0; en = 0; stc = 0; src = SLD_SRC_XTAL; rate = SLD_RATE_16; vl = 4'h0;
      bsel = 3'h0; sl = 8'h00; sh = 8'h00; stop = 0; keep = 0; wi = 0; wd = 0; wdat = 8'h00;
      cyc(1);
      @(negedge clk);
      check({cown, sown, bsw, cen, ben, fs}, 32'h0);
      @(posedge clk); nrst <= 1'b1;
      // setup order: mode and clock at reset, then map, segment pins, contrast, enable
      for (int i = 0; i < 16; i++) begin
         map_wr(8'hF0 | i[7:0], 8'hA0 | (i[7:0] ^ 8'h05));
         check(idx_o, i);
         check(dat_o, i ^ 5);
      end
      $display("test map done");
      @(posedge clk); sl <= 8'hA5; sh <= 8'h3C;
      cyc(2);
      @(negedge clk);
      check({cown, sown}, 20'h0);
      @(posedge clk); vl <= 4'h9; bsel <= 3'h1; en <= 1'b1;
      cyc(2);
      @(negedge clk);
      check({cown, sown}, 20'hF3CA5);
      check({bsw, cen, ben, ccode, bres}, 10'h3C9);
      check({clat, slat}, 20'h0);
      // frame wrap: levels of the last step, then of common 0 at positive polarity
      wait_frame();
      check(clvl, 8'h2A);
      check(slvl, 32'hFFFF5555);
      @(negedge clk);
      check(clvl, 8'h57);
      check(slvl, 32'h88888888);
      $display("test pins done");
      for (int r = 0; r < 4; r++) begin
         @(posedge clk); rate <= sld_rate_e'(r);
         wait_frame(); wait_frame();
         @(negedge clk);
         check(per, 8 * (16 << r) * 10);
         check(seen, 4'hF);
      end
      @(posedge clk); rate <= SLD_RATE_16; src <= SLD_SRC_RC;
      wait_frame(); wait_frame();
      @(negedge clk);
      check(per, 8 * 16 * 12);
      $display("test timing done");
      @(posedge clk); stc <= 1'b1;
      cyc(2);
      @(negedge clk);
      check({bsw, cen, ben}, 3'h0);
      check(clvl, 8'h0);
      check(slvl, 32'h0);
      wait_frame();
      check({clat, slat}, 20'hF28A0);
      @(negedge clk);
      check({clat, slat}, 20'h01405);
      $display("test static done");
      @(posedge clk); stc <= 1'b0; src <= SLD_SRC_XTAL; stop <= 1'b1;
      n = 0;
      cyc(200);
      repeat (3000) begin
         @(negedge clk);
         if (fs === 1'b1) n++;
      end
      check(n, 0);
      @(posedge clk); keep <= 1'b1;
      wait_frame(); wait_frame();
      @(negedge clk);
      check(per, 8 * 16 * 10);
      $display("test stop done");
      give_verdict();
   end
endmodule // test_sld_panel_drv
